// ==== hpw_power_switch_watchdog.sv ====
`timescale 1ns/1ps
module hpw_power_switch_watchdog
#(
  parameter int TICK_CYCLES = hpw_pkg::TICK_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [7:0] cmdType,
  input wire logic [4:0] cmdLen,
  input wire logic [7:0] cmdData0,
  input wire logic [7:0] cmdData1,
  input wire logic [7:0] cmdData2,
  input wire logic keyConfirm,
  input wire logic keyCancel,
  input wire logic hostSenseIn,
  input wire logic senseFuncUser,
  input wire logic powerFuncUser,
  input wire logic resetFuncUser,
  input wire logic rstLineIn,
  output logic rstLineOut,
  output logic rstLineOe,
  input wire logic pwrLineIn,
  output logic pwrLineOut,
  output logic pwrLineOe,
  output logic ackValid,
  output logic [7:0] ackType,
  output logic [4:0] ackLen,
  output logic [7:0] statusMask,
  output logic [7:0] statusWdog,
  output logic displayOn,
  output logic backlightOn,
  output logic indicatorsOn,
  output logic moduleAlwaysOn,
  output logic moduleRestart
);
  import hpw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hpw_state_e state_r;                  // Sequencer state
  hpw_state_e stateNxt;                 // Next sequencer state
  logic [TICK_W-1:0] subCnt_r;          // Divider toward 1/32 s tick
  logic tickPulse_r;                    // One cycle per tick
  logic [7:0] mask_r;                   // Working function mask
  logic [7:0] pulseLen_r;               // Power pulse length in ticks
  logic [7:0] extra_r;                  // Extra power functions
  logic [7:0] bootMask_r;               // Stored boot mask
  logic [7:0] bootPulse_r;              // Stored boot pulse length
  logic [7:0] bootExtra_r;              // Stored boot extra functions
  logic [CNT_W-1:0] holdCnt_r [2];      // Key hold time, confirm then cancel
  logic [CNT_W-1:0] pulseCnt_r;         // Ticks spent in current state
  logic [3:0] restartCnt_r;             // Cycles of self restart
  logic [7:0] wdogCnt_r;                // Watchdog seconds left, zero is off
  logic [CNT_W-1:0] wdogSub_r;          // Ticks within a watchdog second
  logic fromCancel_r;                   // Power pulse came from cancel key
  logic senseAtStart_r;                 // Sense level when the pulse began
  logic sensePrev_r;                    // Sense one cycle ago
  logic ackValid_r;
  logic [7:0] ackType_r;
  logic [4:0] ackLen_r;
  logic displayOn_r;
  logic backlightOn_r;
  logic indicatorsOn_r;
  logic moduleAlwaysOn_r;
  logic moduleRestart_r;

  // True in the states that drive the power line
  function automatic logic isPowerState(input hpw_state_e s);
    isPowerState = (s == ST_PWR_PULSE) || (s == ST_PWR_EXTEND);
  endfunction

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  wire tickWrap = (subCnt_r == TICK_W'(TICK_CYCLES - 1));

  // Free running divider, one tick each 1/32 second
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      subCnt_r <= '0;
      tickPulse_r <= 1'b0;
    end
    else
    begin
      subCnt_r <= tickWrap ? '0 : subCnt_r + TICK_W'(1);
      tickPulse_r <= tickWrap;
    end
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // sense pin in user mode reads as host off
  wire senseHi = hostSenseIn & ~senseFuncUser;
  wire senseRise = senseHi & ~sensePrev_r;
  // no command taken during self restart
  wire cmdOpen = cmdValid && (state_r != ST_RESTART);
  // config accepted with one to three bytes
  wire cfgAccept = cmdOpen && (cmdType == CMD_CONFIG) && (cmdLen >= CFG_LEN_MIN)
    && (cmdLen <= CFG_LEN_EXTRA);
  wire wdogAccept = cmdOpen && (cmdType == CMD_WDOG) && (cmdLen == WDOG_LEN);
  wire statAccept = cmdOpen && (cmdType == CMD_STATUS) && (cmdLen == LEN_ZERO);
  wire storeAccept = cmdOpen && (cmdType == CMD_STORE) && (cmdLen == LEN_ZERO);
  wire anyAccept = cfgAccept | wdogAccept | statAccept | storeAccept;
  wire restartDone = (state_r == ST_RESTART) && (restartCnt_r == RESTART_LAST);
  wire idle = (state_r == ST_IDLE);
  wire [1:0] keyHeld = {keyCancel, keyConfirm};
  // sense rise restarts the module in blank mode
  wire hostUpRestart = mask_r[MASK_BLANK] && senseRise;
  // confirm held long enough with host on
  wire keyResetGo = mask_r[MASK_KEY_RESET] && senseHi && keyConfirm && tickPulse_r
    && (holdCnt_r[0] == KEY_RESET_HOLD_TICKS - CNT_ONE);
  // short confirm press with host off
  wire ponGo = mask_r[MASK_KEY_PON] && !senseHi && keyConfirm && tickPulse_r
    && (holdCnt_r[0] == POWER_ON_PRESS_TICKS - CNT_ONE);
  // cancel hold power down enable bit
  wire poffGo = mask_r[MASK_KEY_POFF] && senseHi && keyCancel && tickPulse_r
    && (holdCnt_r[1] == POWER_OFF_HOLD_TICKS - CNT_ONE);
  wire secTick = tickPulse_r && (wdogSub_r == WDOG_SECOND_TICKS - CNT_ONE);
  // expiry when the last second runs out
  wire wdogFire = idle && (wdogCnt_r == CNT_ONE) && secTick && !wdogAccept && !hostUpRestart;
  wire holdMode = (pulseLen_r == PULSE_HOLD);
  wire [CNT_W-1:0] lenEff = (pulseLen_r == '0) ? CNT_ONE : pulseLen_r;
  // length in ticks, or hold until sense changes
  wire pwrDone = holdMode ? (senseHi != senseAtStart_r)
    : (tickPulse_r && (pulseCnt_r == lenEff - CNT_ONE));
  wire rstDone = tickPulse_r && (pulseCnt_r == RESET_PULSE_TICKS - CNT_ONE);
  wire extDone = tickPulse_r && (pulseCnt_r == POWER_EXTEND_TICKS - CNT_ONE);
  // requests exist only in the pulse and extend states
  wire rstReq = (stateNxt == ST_RST_PULSE) && !resetFuncUser;
  wire pwrReq = isPowerState(stateNxt) && !powerFuncUser;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state; restart from host rise wins over key starts
  always_comb
  begin
    stateNxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (hostUpRestart)
          stateNxt = ST_RESTART;
        else if (wdogFire || keyResetGo)
          stateNxt = ST_RST_PULSE;
        else if (ponGo || poffGo)
          stateNxt = ST_PWR_PULSE;
      end
      ST_RST_PULSE:
      begin
        // reset pulse is followed by self restart
        if (rstDone)
          stateNxt = ST_RESTART;
      end
      ST_PWR_PULSE:
      begin
        if (hostUpRestart)
          stateNxt = ST_RESTART;
        else if (pwrDone)
          // cancel still held extends the drive
          stateNxt = (fromCancel_r && keyCancel) ? ST_PWR_EXTEND : ST_IDLE;
      end
      ST_PWR_EXTEND:
      begin
        if (hostUpRestart)
          stateNxt = ST_RESTART;
        else if (!keyCancel || extDone)
          stateNxt = ST_IDLE;
      end
      ST_RESTART:
      begin
        if (restartDone)
          stateNxt = ST_IDLE;
      end
    endcase
  end

  // State and per-state tick counter
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      pulseCnt_r <= '0;
    end
    else
    begin
      state_r <= stateNxt;
      if (stateNxt != state_r)
        pulseCnt_r <= '0;
      else if (tickPulse_r && pulseCnt_r != CNT_MAX)
        pulseCnt_r <= pulseCnt_r + CNT_ONE;
    end
  end

  // Pulse context captured while idle, restart length counter
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fromCancel_r <= 1'b0;
      senseAtStart_r <= 1'b0;
      sensePrev_r <= 1'b0;
      restartCnt_r <= '0;
    end
    else
    begin
      if (idle)
      begin
        fromCancel_r <= poffGo;
        senseAtStart_r <= senseHi;
      end
      sensePrev_r <= senseHi;
      restartCnt_r <= (state_r == ST_RESTART) ? restartCnt_r + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Key hold counters
  // ----------------------------------------------------------------
  genvar gk;
  generate
    for (gk = 0; gk < 2; gk++)
    begin : g_hold
      // Counts ticks a key stays down; cleared on release or restart
      always_ff @(posedge clk)
      begin
        if (!rstn || !keyHeld[gk] || state_r == ST_RESTART)
          holdCnt_r[gk] <= '0;
        else if (tickPulse_r && holdCnt_r[gk] != CNT_MAX)
          holdCnt_r[gk] <= holdCnt_r[gk] + CNT_ONE;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Configuration and boot store
  // ----------------------------------------------------------------
  // Working settings; reload from the boot store on self restart
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mask_r <= MASK_DEFAULT;
      pulseLen_r <= PULSE_DEFAULT;
      extra_r <= EXTRA_DEFAULT;
    end
    else if (restartDone)
    begin
      mask_r <= bootMask_r;
      pulseLen_r <= bootPulse_r;
      extra_r <= bootExtra_r;
    end
    else if (cfgAccept)
    begin
      // mask bits enable the key functions
      mask_r <= cmdData0;
      if (cmdLen >= CFG_LEN_PULSE)
        pulseLen_r <= cmdData1;
      if (cmdLen >= CFG_LEN_EXTRA)
        extra_r <= cmdData2;
    end
  end

  // store command saves the working settings
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bootMask_r <= MASK_DEFAULT;
      bootPulse_r <= PULSE_DEFAULT;
      bootExtra_r <= EXTRA_DEFAULT;
    end
    else if (storeAccept)
    begin
      bootMask_r <= mask_r;
      bootPulse_r <= pulseLen_r;
      bootExtra_r <= extra_r;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // off after reset and after every self restart
  always_ff @(posedge clk)
  begin
    if (!rstn || restartDone)
    begin
      wdogCnt_r <= '0;
      wdogSub_r <= '0;
    end
    else if (wdogAccept)
    begin
      // arm with the given seconds, zero disarms
      wdogCnt_r <= cmdData0;
      wdogSub_r <= '0;
    end
    else if (wdogCnt_r != '0 && idle && tickPulse_r)
    begin
      wdogSub_r <= secTick ? '0 : wdogSub_r + CNT_ONE;
      // count reaching zero leaves it disarmed
      if (secTick)
        wdogCnt_r <= wdogCnt_r - CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge and display outputs
  // ----------------------------------------------------------------
  // acknowledge type is request with bit 6 set
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ackValid_r <= 1'b0;
      ackType_r <= '0;
      ackLen_r <= '0;
    end
    else
    begin
      ackValid_r <= anyAccept;
      ackType_r <= anyAccept ? (cmdType | ACK_FLAG) : ackType_r;
      ackLen_r <= statAccept ? STATUS_LEN : (anyAccept ? LEN_ZERO : ackLen_r);
    end
  end

  // blank screen and backlight while host is off
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      displayOn_r <= 1'b1;
      backlightOn_r <= 1'b1;
      indicatorsOn_r <= 1'b1;
      moduleAlwaysOn_r <= 1'b0;
      moduleRestart_r <= 1'b0;
    end
    else
    begin
      displayOn_r <= !(mask_r[MASK_BLANK] && !senseHi);
      backlightOn_r <= !(mask_r[MASK_BLANK] && !senseHi);
      // indicator bit only counts with blanking on
      indicatorsOn_r <= !(mask_r[MASK_BLANK] && mask_r[MASK_INDICATORS_DARK] && !senseHi);
      moduleAlwaysOn_r <= (extra_r == EXTRA_ALWAYS_ON);
      moduleRestart_r <= (stateNxt == ST_RESTART);
    end
  end

  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // drive asserted level, release to end the pulse
  hpw_line_driver u_rst_drv
  (
    .clk(clk),
    .rstn(rstn),
    .assertReq(rstReq),
    .autoPol(mask_r[MASK_AUTO_POL]),
    .invert(mask_r[MASK_RESET_INV]),
    .lineIn(rstLineIn),
    .lineOut(rstLineOut),
    .lineOe(rstLineOe)
  );

  // power line polarity from its own invert bit unless the auto polarity bit is set
  hpw_line_driver u_pwr_drv
  (
    .clk(clk),
    .rstn(rstn),
    .assertReq(pwrReq),
    .autoPol(mask_r[MASK_AUTO_POL]),
    .invert(mask_r[MASK_POWER_INV]),
    .lineIn(pwrLineIn),
    .lineOut(pwrLineOut),
    .lineOe(pwrLineOe)
  );

  // pins left in default role by the host
  assign ackValid = ackValid_r;
  assign ackType = ackType_r;
  assign ackLen = ackLen_r;
  assign statusMask = mask_r;
  assign statusWdog = wdogCnt_r;
  assign displayOn = displayOn_r;
  assign backlightOn = backlightOn_r;
  assign indicatorsOn = indicatorsOn_r;
  assign moduleAlwaysOn = moduleAlwaysOn_r;
  assign moduleRestart = moduleRestart_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rst_line_hiz: assert property (@(posedge clk) disable iff (!rstn)
    (state_r != ST_RST_PULSE) |-> !rstLineOe) else $error("reset line driven outside pulse");
  a_pwr_line_hiz: assert property (@(posedge clk) disable iff (!rstn)
    !isPowerState(state_r) |-> !pwrLineOe) else $error("power line driven outside pulse");
  a_rst_drive_lvl: assert property (@(posedge clk) disable iff (!rstn)
    (rstLineOe && !$past(mask_r[MASK_AUTO_POL])) |-> (rstLineOut == $past(mask_r[MASK_RESET_INV])))
    else $error("reset line level does not follow invert bit");
  a_rst_pulse_len: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_RST_PULSE && !(tickPulse_r && pulseCnt_r == RESET_PULSE_TICKS - CNT_ONE))
    |=> (state_r == ST_RST_PULSE)) else $error("reset pulse ended early");
  a_restart_follow: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_RST_PULSE) ##1 (state_r != ST_RST_PULSE) |-> (state_r == ST_RESTART))
    else $error("reset pulse not followed by restart");
  a_cmd_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_RESTART && cmdValid) |=> !ackValid_r) else $error("command taken in restart");
  a_extend_max: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_PWR_EXTEND) |-> (pulseCnt_r < POWER_EXTEND_TICKS)) else $error("extension too long");
  a_blank_host_off: assert property (@(posedge clk) disable iff (!rstn)
    (mask_r[MASK_BLANK] && !senseHi) |=> (!displayOn_r && !backlightOn_r)) else $error("display lit");
  a_leds_need_blank: assert property (@(posedge clk) disable iff (!rstn)
    !mask_r[MASK_BLANK] |=> indicatorsOn_r) else $error("indicators dark without blanking");
  a_wdog_disarm: assert property (@(posedge clk) disable iff (!rstn)
    wdogFire |=> (wdogCnt_r == '0) && (state_r == ST_RST_PULSE)) else $error("watchdog still armed");
  a_cfg_ack: assert property (@(posedge clk) disable iff (!rstn)
    cfgAccept |=> ackValid_r && (ackType_r == (CMD_CONFIG | ACK_FLAG)) && (ackLen_r == LEN_ZERO))
    else $error("config not acknowledged");

endmodule // hpw_power_switch_watchdog

// ==== hpw_pkg.sv ====
// Summary of operation
// - Reset and power lines idle undriven
// - Pulse drives asserted level, ends undriven
// - Mask polarity bits: auto, reset, power invert
// - Confirm held 4 s pulses reset 1 s
// - Commands ignored until self restart completes
// - Confirm 0.25 s with host off pulses power
// - Cancel held 4 s powers off, extends 5 s
// - Blank display and backlight while host off
// - Host sense rise restarts module when blanking
// - Indicator dark bit needs blanking bit set
// - Mask bits enable key reset, power up
// - Config command carries mask and pulse length
// - Third config byte selects always-on operation
// - Watchdog command arms seconds, zero disarms
// - Watchdog expiry pulses reset like key reset
// - No second watchdog reset until rearmed
// - Watchdog disarmed after every module power up
// - Status read returns mask and watchdog count
// - Store command saves settings, restored at startup
// - Function bit zero keeps pin default role
package hpw_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;             // Core clock rate
  localparam int TICK_HZ = 32;                    // Tick is 1/32 second
  localparam int TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 21;                     // Width of tick divider
  localparam int CNT_W = 8;                       // Width of tick counters

  // ----------------------------------------------------------------
  // Times in milliseconds and their tick counts
  // ----------------------------------------------------------------
  localparam int KEY_RESET_HOLD_MS = 4000;
  localparam int RESET_PULSE_MS = 1000;
  localparam int POWER_ON_PRESS_MS = 250;
  localparam int POWER_OFF_HOLD_MS = 4000;
  localparam int POWER_EXTEND_MS = 5000;
  localparam int WDOG_SECOND_MS = 1000;
  localparam logic [CNT_W-1:0] KEY_RESET_HOLD_TICKS = 8'((KEY_RESET_HOLD_MS * TICK_HZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RESET_PULSE_TICKS = 8'((RESET_PULSE_MS * TICK_HZ + 999) / 1000);
  localparam logic [CNT_W-1:0] POWER_ON_PRESS_TICKS = 8'((POWER_ON_PRESS_MS * TICK_HZ + 999) / 1000);
  localparam logic [CNT_W-1:0] POWER_OFF_HOLD_TICKS = 8'((POWER_OFF_HOLD_MS * TICK_HZ + 999) / 1000);
  localparam logic [CNT_W-1:0] POWER_EXTEND_TICKS = 8'((POWER_EXTEND_MS * TICK_HZ) / 1000);
  localparam logic [CNT_W-1:0] WDOG_SECOND_TICKS = 8'((WDOG_SECOND_MS * TICK_HZ + 999) / 1000);
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;   // Saturation value
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Function mask fields and defaults
  // ----------------------------------------------------------------
  localparam int MASK_AUTO_POL = 0;
  localparam int MASK_RESET_INV = 1;
  localparam int MASK_POWER_INV = 2;
  localparam int MASK_INDICATORS_DARK = 3;        // indicators_dark_with_display
  localparam int MASK_BLANK = 4;                  // blank_when_host_down
  localparam int MASK_KEY_RESET = 5;
  localparam int MASK_KEY_PON = 6;
  localparam int MASK_KEY_POFF = 7;
  localparam logic [7:0] MASK_DEFAULT = 8'h01;
  localparam logic [7:0] PULSE_DEFAULT = 8'hff;
  localparam logic [7:0] PULSE_HOLD = 8'hff;      // Hold until sense changes
  localparam logic [7:0] EXTRA_DEFAULT = 8'h00;
  localparam logic [7:0] EXTRA_ALWAYS_ON = 8'h01;
  localparam logic IDLE_LVL_DEFAULT = 1'b1;       // Assumed idle level of a line

  // ----------------------------------------------------------------
  // Command packets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STORE = 8'h04;
  localparam logic [7:0] CMD_CONFIG = 8'h1c;
  localparam logic [7:0] CMD_WDOG = 8'h1d;
  localparam logic [7:0] CMD_STATUS = 8'h1e;
  localparam logic [7:0] ACK_FLAG = 8'h40;
  localparam logic [4:0] LEN_ZERO = 5'h00;
  localparam logic [4:0] CFG_LEN_MIN = 5'h01;
  localparam logic [4:0] CFG_LEN_PULSE = 5'h02;
  localparam logic [4:0] CFG_LEN_EXTRA = 5'h03;
  localparam logic [4:0] WDOG_LEN = 5'h01;
  localparam logic [4:0] STATUS_LEN = 5'h0f;
  localparam logic [3:0] RESTART_LAST = 4'hf;     // Last cycle of self restart

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST_PULSE,
    ST_PWR_PULSE,
    ST_PWR_EXTEND,
    ST_RESTART
  } hpw_state_e;

endpackage

// ==== hpw_line_driver.sv ====
`timescale 1ns/1ps
module hpw_line_driver
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic assertReq,
  input wire logic autoPol,
  input wire logic invert,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe
);
  import hpw_pkg::*;

  // ----------------------------------------------------------------
  // Polarity and drive
  // ----------------------------------------------------------------
  logic idleLvl_r;   // Level the line rests at while undriven
  logic lineOut_r;   // Driven level
  logic lineOe_r;    // Drive enable

  // Auto mode drives against the observed idle level
  wire driveLvl = autoPol ? ~idleLvl_r : invert;

  // Learns the idle level only while the line is released
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      idleLvl_r <= IDLE_LVL_DEFAULT;
      lineOut_r <= 1'b0;
      lineOe_r <= 1'b0;
    end
    else
    begin
      if (!lineOe_r)
      begin
        idleLvl_r <= lineIn;
      end
      lineOut_r <= assertReq ? driveLvl : 1'b0;
      lineOe_r <= assertReq;
    end
  end

  assign lineOut = lineOut_r;
  assign lineOe = lineOe_r;

endmodule // hpw_line_driver

// ==== hpw_host_atx.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the reset and power wires
// ----------------------------------------
module hpw_host_atx
(
  input wire logic rstLineOut,
  input wire logic rstLineOe,
  input wire logic pwrLineOut,
  input wire logic pwrLineOe,
  output logic rstLineIn,
  output logic pwrLineIn
);
  // released wire pulled up
  // Host inputs carry pull-ups, so an undriven wire reads high
  assign rstLineIn = rstLineOe ? rstLineOut : 1'b1;
  assign pwrLineIn = pwrLineOe ? pwrLineOut : 1'b1;
endmodule // hpw_host_atx

// ==== hpw_power_switch_watchdog_test.sv ====
`timescale 1ns/1ps
module hpw_power_switch_watchdog_test;
  import hpw_pkg::*;
  // Bench-driven inputs
  logic clk, rstn, cmdValid, keyConfirm, keyCancel, hostSenseIn, ack;
  logic senseFuncUser, powerFuncUser, resetFuncUser;
  logic [7:0] cmdType, cmdData0, cmdData1, cmdData2;
  logic [4:0] cmdLen;
  // Design outputs and host wires
  logic rstLineIn, rstLineOut, rstLineOe, pwrLineIn, pwrLineOut, pwrLineOe, ackValid;
  logic [7:0] ackType, statusMask, statusWdog;
  logic [4:0] ackLen;
  logic displayOn, backlightOn, indicatorsOn, moduleAlwaysOn, moduleRestart;
  int failCount = 0, samplesChecked = 0, cycles = 0, n;
  hpw_power_switch_watchdog #(.TICK_CYCLES(4)) u_dut (.*);
  hpw_host_atx u_host (.*);
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      giveVerdict();
    end
  end
  task giveVerdict();
    $display("Compares %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e)
    begin
      failCount++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One command; the ack is looked at in the cycle after the taking edge
  task cmd(input logic [7:0] t, input logic [4:0] l, input logic [7:0] d0, input logic [7:0] d1);
    cmdType = t;
    cmdLen = l;
    cmdData0 = d0;
    cmdData1 = d1;
    cmdValid = 1'b1;
    @(negedge clk);
    ack = ackValid;
    cmdValid = 1'b0;
    @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task tConfig();
    cmd(CMD_CONFIG, 5'h00, 8'h40, 8'h00);
    chk(ack, 1'b0);
    cmd(CMD_CONFIG, 5'h01, 8'h40, 8'h00);
    chk(ack, 1'b1);
    chk(ackType, 8'h5c);
    chk(statusMask, 8'h40);
    cmd(CMD_STATUS, 5'h00, 8'h00, 8'h00);
    chk(ackType, 8'h5e);
    chk({3'h0, ackLen}, 8'h0f);
    $display("config done");
  endtask
  task tPowerUp();
    cmd(CMD_CONFIG, 5'h02, 8'h40, 8'h02);
    keyConfirm = 1'b1;
    for (n = 0; n < 100 && pwrLineOe !== 1'b1; n++) @(negedge clk);
    chk(pwrLineOe, 1'b1);
    chk(pwrLineOut, 1'b0);
    for (n = 0; n < 40 && pwrLineOe === 1'b1; n++) @(negedge clk);
    chk(n >= 7 && n <= 9, 1'b1);
    keyConfirm = 1'b0;
    chk({pwrLineOe, rstLineOe}, 8'h00);
    $display("power up done");
  endtask
  task tBlank();
    cmd(CMD_CONFIG, 5'h01, 8'h18, 8'h00);
    chk({displayOn, backlightOn, indicatorsOn}, 8'h00);
    cmd(CMD_CONFIG, 5'h01, 8'h08, 8'h00);
    chk({displayOn, indicatorsOn}, 8'h03);
    cmd(CMD_CONFIG, 5'h01, 8'h10, 8'h00);
    hostSenseIn = 1'b1;
    for (n = 0; n < 5 && moduleRestart !== 1'b1; n++) @(negedge clk);
    chk(moduleRestart, 1'b1);
    for (n = 0; n < 40 && moduleRestart === 1'b1; n++) @(negedge clk);
    chk(statusMask, MASK_DEFAULT);
    $display("blank done");
  endtask
  task tWatchdog();
    cmd(CMD_CONFIG, 5'h01, 8'h02, 8'h00);
    cmd(CMD_STORE, 5'h00, 8'h00, 8'h00);
    chk(ack, 1'b1);
    cmd(CMD_WDOG, 5'h01, 8'h01, 8'h00);
    chk(statusWdog, 8'h01);
    for (n = 0; n < 300 && rstLineOe !== 1'b1; n++) @(negedge clk);
    chk(rstLineOe, 1'b1);
    chk(rstLineOut, 1'b1);
    for (n = 0; n < 200 && moduleRestart !== 1'b1; n++) @(negedge clk);
    cmd(CMD_STATUS, 5'h00, 8'h00, 8'h00);
    chk(ack, 1'b0);
    for (n = 0; n < 40 && moduleRestart === 1'b1; n++) @(negedge clk);
    chk(statusMask, 8'h02);
    chk(statusWdog, 8'h00);
    for (n = 0; n < 300 && rstLineOe !== 1'b1; n++) @(negedge clk);
    chk(rstLineOe, 1'b0);
    $display("watchdog done");
  endtask
  task tExtra();
    cmdData2 = 8'h01;
    cmd(CMD_CONFIG, 5'h03, 8'h10, 8'hff);
    chk(moduleAlwaysOn, 1'b1);
    senseFuncUser = 1'b1;
    repeat (2) @(negedge clk);
    chk(displayOn, 1'b0);
    cmd(CMD_CONFIG, 5'h01, 8'h00, 8'h00);
    {senseFuncUser, cmdData2} = 9'h000;
    $display("extra done");
  endtask
  task tKeyReset();
    cmd(CMD_CONFIG, 5'h01, 8'h21, 8'h00);
    keyConfirm = 1'b1;
    for (n = 0; n < 600 && rstLineOe !== 1'b1; n++) @(negedge clk);
    chk(rstLineOe, 1'b1);
    chk(rstLineOut, 1'b0);
    for (n = 0; n < 200 && rstLineOe === 1'b1; n++) @(negedge clk);
    chk(n >= 124 && n <= 132, 1'b1);
    keyConfirm = 1'b0;
    chk(moduleRestart, 1'b1);
    for (n = 0; n < 40 && moduleRestart === 1'b1; n++) @(negedge clk);
    chk(statusMask, 8'h02);
    $display("key reset done");
  endtask
  task tPowerDown();
    cmd(CMD_CONFIG, 5'h02, 8'h81, 8'h02);
    keyCancel = 1'b1;
    for (n = 0; n < 600 && pwrLineOe !== 1'b1; n++) @(negedge clk);
    chk(pwrLineOe, 1'b1);
    chk(pwrLineOut, 1'b0);
    for (n = 0; n < 800 && pwrLineOe === 1'b1; n++) @(negedge clk);
    chk(n >= 640 && n <= 656, 1'b1);
    keyCancel = 1'b0;
    $display("power down done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn, cmdValid, keyConfirm, keyCancel, hostSenseIn} = 5'h00;
    {senseFuncUser, powerFuncUser, resetFuncUser} = 3'h0;
    {cmdType, cmdData0, cmdData1, cmdData2, cmdLen} = 37'h0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk({rstLineOe, pwrLineOe}, 8'h00);
    chk(statusWdog, 8'h00);
    chk(statusMask, MASK_DEFAULT);
    tConfig();
    tPowerUp();
    tBlank();
    tWatchdog();
    tExtra();
    tKeyReset();
    tPowerDown();
    giveVerdict();
  end
endmodule // hpw_power_switch_watchdog_test
